// >>> hdl/cfr_result_bank.sv
// Cable reflection result bank: control, results, interrupts
`timescale 1ns/100ps
`include "cfr_consts.svh"

// Functional notes
// - Result bit 9 is one when the measurement found a fault.
// - Result bit 8 is one for a short, zero for open.
// - Result bits 7:0 give fault distance in 1.5 metre steps.
// - Peak code equals distance steps plus four.
// - Peaks one and two at 0x0180, three and four at 0x0181.
// - Polarity bits 14..11 serve peaks four down to one; one is negative.
// - A short shows negative polarity, an open shows positive.
// - Result fields are read-only, reset to zero, reserved bits zero.
// - Writing one to control bit 15 starts; hardware clears it.
// - Control bit 1 is set at a good completion, zero while incomplete or after a failure.
// - Control bit 0 is set when the measurement fails.
module cfr_result_bank #(
    parameter int unsigned TIMEOUT_CYC =
        `CFR_TIMEOUT_US * `CFR_CLK_MHZ
) (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    output logic measurement_start_o,
    input wire logic measurement_done_i,
    input wire logic measurement_failed_i,
    input wire logic fault_found_i,
    input wire logic fault_short_i,
    input wire logic [7:0] fault_dist_i,
    input wire logic [3:0] peak_found_i,
    input wire logic [3:0] peak_short_i,
    input wire logic [31:0] peak_steps_i,
    output logic irq_o
);
    // Watchdog width covers the default with room to spare
    localparam int unsigned TMO_W = 24;

    // Sequencer state
    cfr_pkg::cfr_state_t state;
    cfr_pkg::cfr_state_t next_state;

    // Control register bits
    logic ctrl_start;
    logic ctrl_done;
    logic ctrl_fail;
    logic next_start;
    logic next_done;
    logic next_fail;

    // Watchdog against an engine that never answers
    logic [TMO_W-1:0] tmo_cnt;
    logic [TMO_W-1:0] next_tmo_cnt;
    logic tmo_hit;

    // Interrupt enable register and sticky status
    logic [1:0] irq_enable;
    logic [1:0] irq_status;

    // Captured results
    cfr_result_if res ();

    // Write decode
    wire wr_ctrl = reg_wr_i && (reg_addr_i == `CFR_OFF_CTRL);
    wire wr_irq_en = reg_wr_i && (reg_addr_i == `CFR_OFF_IRQ_ENABLE);
    wire wr_irq_clr = reg_wr_i && (reg_addr_i == `CFR_OFF_IRQ_CLEAR);
    wire start_req = wr_ctrl && reg_wdata_i[`CFR_CTRL_START];

    // Engine answers are only honoured while a run is open
    wire running = (state == cfr_pkg::CFR_RUN);
    wire end_ok = running && measurement_done_i && !measurement_failed_i;
    wire end_fail = running && (measurement_failed_i || tmo_hit);
    wire finish = end_ok || end_fail;

    // A start written during a run is ignored: the engine has one job
    wire launch = start_req && !running;

    // Watchdog compare
    assign tmo_hit = running && !measurement_done_i &&
        (tmo_cnt == TMO_W'(TIMEOUT_CYC - 1));

    // Sequencer next state
    always_comb begin
        next_state = state;
        unique case (state)
            cfr_pkg::CFR_IDLE: begin
                if (launch) begin
                    next_state = cfr_pkg::CFR_RUN;
                end
            end
            cfr_pkg::CFR_RUN: begin
                if (finish) begin
                    next_state = cfr_pkg::CFR_IDLE;
                end
            end
        endcase
    end

    // Watchdog counts only inside a run
    always_comb begin
        if (running && !finish) begin
            next_tmo_cnt = tmo_cnt + TMO_W'(1);
        end else begin
            next_tmo_cnt = '0;
        end
    end

    // Start bit stays high through the run, then clears by itself
    always_comb begin
        next_start = ctrl_start;
        if (launch) begin
            next_start = 1'b1;
        end else if (finish) begin
            next_start = 1'b0;
        end
    end

    // Done and fail drop at start; done rises on a good end of the run, fail on a failed one
    always_comb begin
        next_done = ctrl_done;
        next_fail = ctrl_fail;
        if (launch) begin
            next_done = 1'b0;
            next_fail = 1'b0;
        end else begin
            if (end_ok) begin
                next_done = 1'b1;
            end
            if (end_fail) begin
                next_fail = 1'b1;
            end
        end
    end

    // Sequencer and control registers
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= cfr_pkg::CFR_IDLE;
            tmo_cnt <= '0;
        end else begin
            state <= next_state;
            tmo_cnt <= next_tmo_cnt;
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_start <= 1'b0;
            ctrl_done <= 1'b0;
            ctrl_fail <= 1'b0;
        end else begin
            ctrl_start <= next_start;
            ctrl_done <= next_done;
            ctrl_fail <= next_fail;
        end
    end

    // Engine start is a one-cycle pulse, straight from a flop
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            measurement_start_o <= 1'b0;
        end else begin
            measurement_start_o <= launch;
        end
    end

    // Interrupt enable, written by software
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_enable <= 2'h0;
        end else if (wr_irq_en) begin
            irq_enable <= reg_wdata_i[1:0];
        end
    end

    // Results clear at start and load only on a good completion
    cfr_peak_encoder u_encoder (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .clear_i(launch),
        .load_i(end_ok),
        .fault_found_i(fault_found_i),
        .fault_short_i(fault_short_i),
        .fault_dist_i(fault_dist_i),
        .peak_found_i(peak_found_i),
        .peak_short_i(peak_short_i),
        .peak_steps_i(peak_steps_i),
        .res(res.encoder)
    );

    // Done and fail events feed the sticky status
    wire [1:0] irq_events = {end_fail, end_ok};

    cfr_irq_ctrl u_irq (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .event_i(irq_events),
        .enable_i(irq_enable),
        .clear_i(wr_irq_clr),
        .clear_mask_i(reg_wdata_i[1:0]),
        .status_o(irq_status),
        .irq_o(irq_o)
    );

    // Read images; every unnamed bit is tied to zero
    wire [15:0] img_ctrl = {ctrl_start, 13'h0000, ctrl_done, ctrl_fail};

    wire [15:0] img_result = {6'h00,
        res.fault_found,
        res.fault_short,
        res.fault_dist};

    wire [15:0] img_loc_low = {res.peak_code[15:8],
        res.peak_code[7:0]};

    wire [15:0] img_loc_high = {res.peak_code[31:24],
        res.peak_code[23:16]};

    // Software may only trust a polarity bit whose peak byte is non-zero;
    // an absent peak always reads positive here, so a stale bit never shows
    wire [15:0] img_polarity = {1'b0, res.peak_neg[3:0],
        11'h000};

    wire [15:0] img_irq_status = {14'h0000, irq_status};
    wire [15:0] img_irq_enable = {14'h0000, irq_enable};

    // Read select; unmapped and write-only offsets read zero
    logic [15:0] rd_mux;

    always_comb begin
        unique case (reg_addr_i)
            `CFR_OFF_CTRL: rd_mux = img_ctrl;
            `CFR_OFF_RESULT: rd_mux = img_result;
            `CFR_OFF_LOC_LOW: rd_mux = img_loc_low;
            `CFR_OFF_LOC_HIGH: rd_mux = img_loc_high;
            `CFR_OFF_POLARITY: rd_mux = img_polarity;
            `CFR_OFF_IRQ_STATUS: rd_mux = img_irq_status;
            `CFR_OFF_IRQ_ENABLE: rd_mux = img_irq_enable;
            default: rd_mux = `CFR_REG_RESET;
        endcase
    end

    // Read data stand for exactly the cycle after the strobe
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reg_rdata_o <= `CFR_REG_RESET;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rd_mux;
        end else begin
            reg_rdata_o <= `CFR_REG_RESET;
        end
    end
endmodule

// >>> hdl/cfr_consts.svh
// Offsets, field positions, reset values and timing of the result bank
`ifndef CFR_CONSTS_SVH
`define CFR_CONSTS_SVH

// Register bus widths
`define CFR_ADDR_W 16
`define CFR_DATA_W 16

// Register offsets on the management port
`define CFR_OFF_CTRL 16'h001E
`define CFR_OFF_RESULT 16'h016B
`define CFR_OFF_LOC_LOW 16'h0180
`define CFR_OFF_LOC_HIGH 16'h0181
`define CFR_OFF_POLARITY 16'h018A
`define CFR_OFF_IRQ_STATUS 16'h01A0
`define CFR_OFF_IRQ_ENABLE 16'h01A1
`define CFR_OFF_IRQ_CLEAR 16'h01A2

// Field positions
`define CFR_CTRL_START 15
`define CFR_CTRL_DONE 1
`define CFR_CTRL_FAIL 0
`define CFR_RES_FAULT 9
`define CFR_RES_SHORT 8
`define CFR_POL_PEAK1 11
`define CFR_IRQ_DONE 0
`define CFR_IRQ_FAIL 1

// Sizes, reset values and encodings
`define CFR_NUM_PEAKS 4
`define CFR_IRQ_W 2
`define CFR_REG_RESET 16'h0000
`define CFR_PEAK_BIAS 8'h04
`define CFR_CODE_MAX 8'hFF

// Engine watchdog: time in microseconds and clock rate in MHz
`define CFR_TIMEOUT_US 10000
`define CFR_CLK_MHZ 250

`endif

// >>> hdl/cfr_pkg.sv
// Types shared by the cable reflection result bank
package cfr_pkg;
    typedef enum logic [0:0] {
        CFR_IDLE,
        CFR_RUN
    } cfr_state_t;

    typedef logic [7:0] cfr_code_t;
    typedef logic [15:0] cfr_word_t;
endpackage

// >>> hdl/cfr_result_if.sv
// Captured measurement results passed from the encoder to the bank
`timescale 1ns/100ps
interface cfr_result_if;
    logic fault_found;
    logic fault_short;
    logic [7:0] fault_dist;
    logic [31:0] peak_code;
    logic [3:0] peak_neg;

    modport encoder (
        output fault_found,
        output fault_short,
        output fault_dist,
        output peak_code,
        output peak_neg
    );

    modport bank (
        input fault_found,
        input fault_short,
        input fault_dist,
        input peak_code,
        input peak_neg
    );
endinterface

// >>> hdl/cfr_peak_encoder.sv
// Encodes and holds the fault and peak results of one measurement
`timescale 1ns/100ps
`include "cfr_consts.svh"
module cfr_peak_encoder (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic clear_i,
    input wire logic load_i,
    input wire logic fault_found_i,
    input wire logic fault_short_i,
    input wire logic [7:0] fault_dist_i,
    input wire logic [3:0] peak_found_i,
    input wire logic [3:0] peak_short_i,
    input wire logic [31:0] peak_steps_i,
    cfr_result_if.encoder res
);
    logic [31:0] next_code;

    // Code is steps plus bias, saturated; an absent peak reads zero
    genvar g;
    generate
        for (g = 0; g < `CFR_NUM_PEAKS; g++) begin : g_peak
            logic [8:0] biased;
            assign biased = {1'b0, peak_steps_i[g*8 +: 8]} +
                {1'b0, `CFR_PEAK_BIAS};
            assign next_code[g*8 +: 8] = !peak_found_i[g] ? 8'h00 :
                biased[8] ? `CFR_CODE_MAX : biased[7:0];
        end
    endgenerate

    // Cleared at start, loaded once at a good completion, held otherwise
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            res.fault_found <= 1'b0;
            res.fault_short <= 1'b0;
            res.fault_dist <= 8'h00;
            res.peak_code <= 32'h0000_0000;
            res.peak_neg <= 4'h0;
        end else if (clear_i) begin
            res.fault_found <= 1'b0;
            res.fault_short <= 1'b0;
            res.fault_dist <= 8'h00;
            res.peak_code <= 32'h0000_0000;
            res.peak_neg <= 4'h0;
        end else if (load_i) begin
            res.fault_found <= fault_found_i;
            res.fault_short <= fault_found_i & fault_short_i;
            res.fault_dist <= fault_found_i ? fault_dist_i : 8'h00;
            res.peak_code <= next_code;
            res.peak_neg <= peak_found_i & peak_short_i;
        end
    end
endmodule

// >>> hdl/cfr_irq_ctrl.sv
// Sticky event status with enable gating onto one level interrupt
`timescale 1ns/100ps
`include "cfr_consts.svh"
module cfr_irq_ctrl (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic [1:0] event_i,
    input wire logic [1:0] enable_i,
    input wire logic clear_i,
    input wire logic [1:0] clear_mask_i,
    output logic [1:0] status_o,
    output logic irq_o
);
    logic [1:0] next_status;

    // A set in the clearing cycle wins, so no event is lost
    assign next_status = (status_o & ~({2{clear_i}} & clear_mask_i)) | event_i;

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            status_o <= 2'h0;
            irq_o <= 1'b0;
        end else begin
            status_o <= next_status;
            irq_o <= |(next_status & enable_i);
        end
    end
endmodule

// >>> dv/cfr_result_bank_props.sv
// Port-level assertions for the cable reflection result bank
`timescale 1ns/100ps
module cfr_result_bank_props #(
    parameter int unsigned TIMEOUT_CYC = 50
) (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic measurement_start_o,
    input wire logic irq_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!arst_n_i);

    // Read decodes seen from the bus side
    wire rd_ctl = reg_rd_i && reg_addr_i == 16'h001E;
    wire rd_res = reg_rd_i && reg_addr_i == 16'h016B;
    wire rd_pol = reg_rd_i && reg_addr_i == 16'h018A;
    wire mapped = reg_addr_i inside {16'h001E, 16'h016B, 16'h0180,
        16'h0181, 16'h018A, 16'h01A0, 16'h01A1, 16'h01A2};

    a_start_single: assert property (measurement_start_o |=>
        !measurement_start_o)
        else $error("start pulse longer than one cycle");
    a_start_cause: assert property (measurement_start_o |->
        $past(reg_wr_i && reg_addr_i == 16'h001E && reg_wdata_i[15]))
        else $error("start pulse without a start write");
    a_rdata_idle: assert property (!$past(reg_rd_i) |->
        reg_rdata_o == 16'h0000)
        else $error("read data outside answer cycle");
    a_res_reserved: assert property ($past(rd_res) |->
        reg_rdata_o[15:10] == 6'h00)
        else $error("result reserved bits set");
    a_nofault_clean: assert property ($past(rd_res) &&
        !reg_rdata_o[9] |-> reg_rdata_o[8:0] == 9'h000)
        else $error("fault fields set without fault");
    a_pol_reserved: assert property ($past(rd_pol) |->
        reg_rdata_o[15] == 1'b0 && reg_rdata_o[10:0] == 11'h000)
        else $error("polarity reserved bits set");
    a_ctrl_flags: assert property ($past(rd_ctl) |->
        reg_rdata_o[14:2] == 13'h0000 && !(reg_rdata_o[1] && reg_rdata_o[0]))
        else $error("control flags inconsistent");
    a_unmapped_zero: assert property ($past(reg_rd_i && !mapped) |->
        reg_rdata_o == 16'h0000)
        else $error("unmapped read not zero");
    // Interrupt may only drop because software wrote clear or enable
    a_irq_fall: assert property ($fell(irq_o) |-> $past(reg_wr_i))
        else $error("interrupt dropped without a write");

    c_start: cover property (measurement_start_o);
    c_irq: cover property ($rose(irq_o));
    c_fail_seen: cover property ($past(rd_ctl) && reg_rdata_o[0]);
endmodule

bind cfr_result_bank cfr_result_bank_props #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_props (
    .mclk_i, .arst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .measurement_start_o, .irq_o);

// >>> dv/cfr_result_bank_tb.sv
// Self-checking bench for the cable reflection result bank
`timescale 1ns/100ps
module cfr_result_bank_tb;
    localparam int unsigned TO_CYC = 50;
    logic mclk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [15:0] reg_addr_i = 16'h0000;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic [15:0] reg_rdata_o;
    logic measurement_start_o, irq_o;
    logic measurement_done_i = 1'b0, measurement_failed_i = 1'b0;
    logic fault_found_i = 1'b0, fault_short_i = 1'b0;
    logic [7:0] fault_dist_i = 8'h00;
    logic [3:0] peak_found_i = 4'h0, peak_short_i = 4'h0;
    logic [31:0] peak_steps_i = 32'h0000_0000;
    integer mismatches = 0, n_tests = 0, seed = 32'h2822, cyc = 0;
    // Model expectations for the result words of the current run
    integer model [$];
    // Read-only and unmapped offsets that must ignore writes
    logic [15:0] ad [6] = '{16'h016B, 16'h0180, 16'h0181, 16'h018A,
        16'h01A0, 16'h0100};

    cfr_result_bank #(.TIMEOUT_CYC(TO_CYC)) DUT (.mclk_i, .arst_n_i,
        .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
        .measurement_start_o, .measurement_done_i, .measurement_failed_i,
        .fault_found_i, .fault_short_i, .fault_dist_i, .peak_found_i,
        .peak_short_i, .peak_steps_i, .irq_o);

    initial forever #2 mclk_i = ~mclk_i;

    // Hang guard: a whole run needs well under a thousand cycles
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            $display("[ERR] %0t cycle limit reached", $time);
            mismatches = mismatches + 1;
            results;
        end
    end

    task automatic results;
        $display("tests %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
            mismatches = mismatches + 1;
        end
    endtask

    // Bus cycles: the strobe stands one cycle, read data the cycle after
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input integer e);
        @(posedge mclk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge mclk_i);
        reg_rd_i <= 1'b0;
        #1 chk(reg_rdata_o, e[15:0]);
    endtask

    // Expected peak code: bias of four, saturating, zero when absent
    function automatic integer code(input integer s, input logic f);
        code = !f ? 0 : (s + 4 > 255) ? 255 : s + 4;
    endfunction

    // Engine results presented with a one-cycle done or fail pulse
    task automatic engine(input logic [31:0] r, input logic [31:0] st,
                          input logic dn, input logic fl);
        @(posedge mclk_i);
        fault_found_i <= r[0];
        fault_short_i <= r[1];
        fault_dist_i <= r[15:8];
        peak_found_i <= r[19:16];
        peak_short_i <= r[23:20];
        peak_steps_i <= st;
        measurement_done_i <= dn;
        measurement_failed_i <= fl;
        @(posedge mclk_i);
        measurement_done_i <= 1'b0;
        measurement_failed_i <= 1'b0;
    endtask

    // Kind 0 succeeds, 1 fails, 2 times out; results then held while idle
    task automatic run(input integer kind, input logic [31:0] st);
        logic [31:0] r;
        logic [1:0] en;
        integer er, lo, hi, pol, k;
        r = $random(seed);
        en = r[25:24];
        wr(16'h01A1, {14'h0000, en});
        wr(16'h001E, 16'h8000);
        #1 chk({15'h0000, measurement_start_o}, 16'h0001);
        rd(16'h001E, 16'h8000);
        rd(16'h016B, 0);
        if (kind == 2) begin
            // A second start inside the run must not launch the engine again
            wr(16'h001E, 16'h8000);
            #1 chk({15'h0000, measurement_start_o}, 16'h0000);
            repeat (TO_CYC + 4) @(posedge mclk_i);
        end
        // A failure beside a done wins; r[26] sometimes raises both
        engine(r, st, kind == 0 || (kind == 1 && r[26]), kind == 1);
        er = r[0] ? 512 + (r[1] ? 256 : 0) + r[15:8] : 0;
        lo = code(st[7:0], r[16]) + 256 * code(st[15:8], r[17]);
        hi = code(st[23:16], r[18]) + 256 * code(st[31:24], r[19]);
        pol = (r[19:16] & r[23:20]) << 11;
        if (kind != 0) begin
            er = 0;
            lo = 0;
            hi = 0;
            pol = 0;
        end
        model = {er, lo, hi, pol};
        for (k = 0; k < 2; k++) begin
            rd(16'h001E, kind ? 1 : 2);
            rd(16'h016B, model[0]);
            rd(16'h0180, model[1]);
            rd(16'h0181, model[2]);
            rd(16'h018A, model[3]);
            engine($random(seed), $random(seed), 1'b1, 1'b0);
        end
        rd(16'h01A0, kind ? 2 : 1);
        chk({15'h0000, irq_o}, {15'h0000, |(en & (kind ? 2'h2 : 2'h1))});
        wr(16'h01A2, 16'h0003);
        rd(16'h01A0, 0);
        chk({15'h0000, irq_o}, 16'h0000);
    endtask

    initial begin
        integer i;
        repeat (20) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        rd(16'h001E, 0);
        rd(16'h01A1, 0);
        foreach (ad[j]) wr(ad[j], 16'hFFFF);
        foreach (ad[j]) rd(ad[j], 0);
        wr(16'h001E, 16'h7FFF);
        rd(16'h001E, 0);
        run(0, 32'hFCFB0100);
        run(1, $random(seed));
        run(2, $random(seed));
        for (i = 0; i < 8; i++) begin
            run(i % 3, $random(seed));
        end
        // Reset in mid-run must drop the control flags, the result word and the interrupt enable
        wr(16'h001E, 16'h8000);
        @(posedge mclk_i);
        arst_n_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        rd(16'h001E, 0);
        rd(16'h016B, 0);
        rd(16'h01A1, 0);
        results;
    end
endmodule
